// ===== hdl/data_mem_consts.svh
/*
 Constants for the internal data memory block: sizes, region limits,
 status word fields and special-function offsets handled here.
 Assumes inclusion by bare name from hdl/.
*/
`ifndef DATA_MEM_CONSTS_SVH
`define DATA_MEM_CONSTS_SVH
`define RAM_BYTES 256
`define LOWER_TOP 8'h7f
`define BANK_AREA_TOP 8'h1f
`define BIT_AREA_BASE 8'h20
`define BIT_AREA_TOP 8'h2f
`define BIT_DIRECT_SFR_BIT 7
`define DPH_OFFSET 8'h83
`define PSW_OFFSET 8'hd0
`define DPH_RESET 8'h00
`define PSW_RESET 8'h00
`define PSW_PARITY_BIT 0
`define PSW_BANK_LOW_BIT 3
`define PSW_BANK_HIGH_BIT 4
`define PSW_WRITE_MASK 8'hfe
`define REG_NUM_MSB 2
`define REG_ZERO 3'h0
`define REG_ONE 3'h1
`define BIT_POS_MSB 2
`define BIT_BYTE_LSB 3
`define BIT_BYTE_MSB 6
`define BIT_SFR_MASK 8'hf8
`define RD_DATA_RESET 8'h00
`define SFR_IDLE_BYTE 8'h00
`endif

// ===== hdl/data_mem_pkg.sv
/*
 Types shared by the internal data memory block.
 Assumes the constants header sits beside it.
*/
package data_mem_pkg;
    typedef enum logic [1:0] {
        mode_direct,
        mode_indirect,
        mode_bank_reg,
        mode_bit
    } access_mode_t;
endpackage

// ===== hdl/internal_ram_bank_select.sv
/*
 Internal data memory: 256-byte RAM, bank registers, bit area, the
 direct/indirect split against special-function space, and the status
 word and data pointer high byte.
 Assumes the core presents one access per cycle on the same clock and
 that unrelated special-function addresses are served elsewhere.
 Reset clears the registers but not the RAM contents.
*/
// Overview of operation
// - There are 256 RAM bytes at addresses 0x00 to 0xff.
// - The lower 128 bytes are the same storage for direct and indirect access.
// - Addresses 0x00 to 0x1f form four banks of eight byte registers.
// - Bytes 0x20 to 0x2f are usable as bytes and as 128 single bits.
// - The upper 128 bytes are only reachable indirectly.
// - Upper RAM and special-function space are separate storage.
// - Direct access above 0x7f goes to special-function space.
// - Indirect access above 0x7f goes to upper RAM.
// - Status word bits 3 and 4 select the active bank.
// - One bank is active and register n sits at bank times eight plus n.
// - Indirect access takes its address from register zero or one of the active bank.
// - Clearing the program write enable returns data-space moves to data memory.
`timescale 1ns/1ns
`include "data_mem_consts.svh"
module internal_ram_bank_select
    import data_mem_pkg::*;
#(
    parameter int RAM_DEPTH = `RAM_BYTES
) (
    input wire logic clk,
    input wire logic reset,
    input wire access_mode_t mode,
    input wire logic [7:0] addr,
    input wire logic index_sel,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] wr_data,
    input wire logic wr_bit,
    input wire logic [7:0] accumulator,
    input wire logic program_write_enable,
    output logic [7:0] rd_data,
    output logic rd_bit,
    output logic rd_valid,
    output logic sfr_other,
    output logic [7:0] data_pointer_high_byte,
    output logic [7:0] program_status_word,
    output logic [1:0] active_bank,
    output logic movx_to_program
);
    // Storage and registers
    logic [7:0] ram [0:RAM_DEPTH-1];
    logic [7:0] dph_reg;
    logic [7:0] dph_next;
    logic [7:0] psw_reg;
    logic [7:0] psw_next;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic rd_bit_reg;
    logic rd_bit_next;
    logic rd_valid_reg;
    logic rd_valid_next;

    // Mode decode
    logic is_direct;
    logic is_indirect;
    logic is_bank;
    logic is_bit;

    // Bank registers and index registers
    logic [2:0] reg_num;
    logic [7:0] bank_addr;
    logic [7:0] bank_reg_zero_addr;
    logic [7:0] bank_reg_one_addr;
    logic [7:0] index_addr;
    logic [7:0] index_value;

    // Bit addressing
    logic [2:0] bit_pos;
    logic [3:0] bit_byte_num;
    logic bit_in_ram;
    logic [7:0] bit_byte;
    logic [7:0] bit_sfr;

    // Target selection
    logic upper_half;
    logic direct_sfr;
    logic bit_sfr_hit;
    logic sfr_access;
    logic to_ram;
    logic [7:0] ram_addr;
    logic [7:0] sfr_addr;
    logic hit_dph;
    logic hit_psw;
    logic hit_other;

    // Read path and write merge
    logic parity_bit;
    logic [7:0] psw_view;
    logic [7:0] ram_byte;
    logic [7:0] sfr_byte;
    logic [7:0] sel_byte;
    logic [7:0] bit_mask;
    logic [7:0] bit_set_byte;
    logic [7:0] bit_clear_byte;
    logic [7:0] bit_merged;
    logic [7:0] store_byte;

    // Write strobes
    logic ram_we;
    logic dph_we;
    logic psw_we;

    assign is_direct = (mode == mode_direct);
    assign is_indirect = (mode == mode_indirect);
    assign is_bank = (mode == mode_bank_reg);
    assign is_bit = (mode == mode_bit);

    assign active_bank = {psw_reg[`PSW_BANK_HIGH_BIT], psw_reg[`PSW_BANK_LOW_BIT]};
    assign reg_num = addr[`REG_NUM_MSB:0];
    // The bank field alone picks the bank, so only one is ever live
    assign bank_addr = 8'({active_bank, reg_num});
    assign bank_reg_zero_addr = 8'({active_bank, `REG_ZERO});
    assign bank_reg_one_addr = 8'({active_bank, `REG_ONE});
    assign index_addr = index_sel ? bank_reg_one_addr : bank_reg_zero_addr;
    // Pointer fetched in the same cycle; an indirect access costs no extra clock
    assign index_value = ram[index_addr];

    // Bit address below 0x80 lands in bytes 0x20..0x2f, above it in SPECIAL_FUNCTION_SPACE bits
    assign bit_pos = addr[`BIT_POS_MSB:0];
    assign bit_byte_num = addr[`BIT_BYTE_MSB:`BIT_BYTE_LSB];
    assign bit_in_ram = ~addr[`BIT_DIRECT_SFR_BIT];
    assign bit_byte = `BIT_AREA_BASE | 8'(bit_byte_num);
    assign bit_sfr = addr & `BIT_SFR_MASK;

    assign upper_half = (addr > `LOWER_TOP);
    assign direct_sfr = is_direct && upper_half;
    assign bit_sfr_hit = is_bit && !bit_in_ram;
    assign sfr_access = direct_sfr || bit_sfr_hit;
    assign to_ram = !sfr_access;
    // Indirect reaches all 256 bytes, including the upper half
    assign ram_addr = is_indirect ? index_value :
        (is_bank ? bank_addr : (is_bit ? bit_byte : addr));
    assign sfr_addr = is_bit ? bit_sfr : addr;
    assign hit_dph = sfr_access && (sfr_addr == `DPH_OFFSET);
    assign hit_psw = sfr_access && (sfr_addr == `PSW_OFFSET);
    assign hit_other = sfr_access && !hit_dph && !hit_psw;

    assign parity_bit = ^accumulator;
    assign psw_view = (psw_reg & `PSW_WRITE_MASK) |
        (8'(parity_bit) << `PSW_PARITY_BIT);
    assign ram_byte = ram[ram_addr];
    assign sfr_byte = hit_dph ? dph_reg : (hit_psw ? psw_view : `SFR_IDLE_BYTE);
    assign sel_byte = to_ram ? ram_byte : sfr_byte;
    assign bit_mask = 8'h01 << bit_pos;
    // Bit writes are read-modify-write on the selected byte within one cycle
    assign bit_set_byte = sel_byte | bit_mask;
    assign bit_clear_byte = sel_byte & ~bit_mask;
    assign bit_merged = wr_bit ? bit_set_byte : bit_clear_byte;
    assign store_byte = is_bit ? bit_merged : wr_data;

    assign ram_we = wr_en && to_ram;
    assign dph_we = wr_en && hit_dph;
    assign psw_we = wr_en && hit_psw;
    assign dph_next = store_byte;
    // Parity is not stored; the held bit stays at its reset value
    assign psw_next = (store_byte & `PSW_WRITE_MASK) |
        (psw_reg & ~`PSW_WRITE_MASK);
    assign rd_data_next = sel_byte;
    assign rd_bit_next = sel_byte[bit_pos];
    assign rd_valid_next = rd_en;

    // No reset on the RAM; contents survive a core reset
    always_ff @(posedge clk) begin
        if (ram_we) begin
            ram[ram_addr] <= store_byte;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            dph_reg <= `DPH_RESET;
        end else if (dph_we) begin
            dph_reg <= dph_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            psw_reg <= `PSW_RESET;
        end else if (psw_we) begin
            psw_reg <= psw_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_valid_next;
        end
    end

    // Read data holds until the next read
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_data_reg <= `RD_DATA_RESET;
            rd_bit_reg <= 1'b0;
        end else if (rd_en) begin
            rd_data_reg <= rd_data_next;
            rd_bit_reg <= rd_bit_next;
        end
    end

    assign rd_data = rd_data_reg;
    assign rd_bit = rd_bit_reg;
    assign rd_valid = rd_valid_reg;
    // Other SPECIAL_FUNCTION_SPACE addresses are served outside; flag them for the core
    assign sfr_other = hit_other;
    assign data_pointer_high_byte = dph_reg;
    assign program_status_word = psw_view;
    // Flash control lives elsewhere; this only steers moves
    assign movx_to_program = program_write_enable;
endmodule

// ===== testbench/core_model.sv
/* Core-side model: one access per call. Assumes the shared clock. */
`timescale 1ns/1ns
module core_model
    import data_mem_pkg::*;
(
    input wire logic clk,
    output access_mode_t mode,
    output logic [7:0] addr,
    output logic [7:0] wr_data,
    output logic index_sel,
    output logic wr_en,
    output logic rd_en,
    output logic wr_bit
);
    initial mode = mode_direct;
    initial {addr, wr_data, index_sel, wr_en, rd_en, wr_bit} = '0;
    task automatic xfer(access_mode_t m, logic [7:0] a, logic w, logic [7:0] d, logic i);
        @(posedge clk) #1 mode = m;
        {addr, index_sel, wr_en, rd_en, wr_data, wr_bit} = {a, i, w, !w, d, d[0]};
        @(posedge clk) #1 {wr_en, rd_en, wr_data} = {2'b00, ~d}; // Stale byte never held
    endtask
endmodule

// ===== testbench/internal_ram_bank_select_tb_top.sv
/* Self-checking bench. Assumes core_model drives the access port. */
`timescale 1ns/1ns
module internal_ram_bank_select_tb_top;
    import data_mem_pkg::*;
    logic clk = 0, reset = 1, program_write_enable = 0, index_sel, wr_en, rd_en, wr_bit, rd_bit;
    logic rd_valid, sfr_other, movx_to_program;
    logic [7:0] accumulator = 8'h00, addr, wr_data, rd_data, program_status_word;
    logic [7:0] data_pointer_high_byte;
    logic [1:0] active_bank;
    access_mode_t mode;
    int num_errors = 0, checks = 0, cyc = 0;
    always #5 clk = ~clk;
    core_model u_core (
        .clk(clk),
        .mode(mode),
        .addr(addr),
        .wr_data(wr_data),
        .index_sel(index_sel),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .wr_bit(wr_bit)
    );
    internal_ram_bank_select dut (
        .clk(clk),
        .reset(reset),
        .mode(mode),
        .addr(addr),
        .index_sel(index_sel),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .wr_data(wr_data),
        .wr_bit(wr_bit),
        .accumulator(accumulator),
        .program_write_enable(program_write_enable),
        .rd_data(rd_data),
        .rd_bit(rd_bit),
        .rd_valid(rd_valid),
        .sfr_other(sfr_other),
        .data_pointer_high_byte(data_pointer_high_byte),
        .program_status_word(program_status_word),
        .active_bank(active_bank),
        .movx_to_program(movx_to_program)
    );
    task automatic chk(string name, logic [7:0] e, logic [7:0] s);
        checks++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", name, e, s);
            num_errors++;
        end
    endtask
    task automatic rd(access_mode_t m, logic [7:0] a, logic i, logic [7:0] e);
        u_core.xfer(m, a, 1'b0, 8'h00, i);
        chk("rd_valid", 8'h01, 8'(rd_valid));
        chk("rd_data", e, rd_data);
    endtask
    task automatic rdb(logic [7:0] a, logic e);
        u_core.xfer(mode_bit, a, 1'b0, 8'h00, 1'b0);
        chk("rd_bit", 8'(e), 8'(rd_bit));
    endtask
    task automatic t_bank();
        rd(mode_direct, 8'hd0, 1'b0, 8'h00);
        for (int b = 0; b < 4; b++) begin
            u_core.xfer(mode_direct, 8'hd0, 1'b1, 8'(b * 8), 1'b0);
            u_core.xfer(mode_bank_reg, 8'h07, 1'b1, 8'(b + 8'h40), 1'b0);
            rd(mode_direct, 8'(b * 8 + 7), 1'b0, 8'(b + 8'h40));
        end
        $display("bank test done");
    endtask
    task automatic t_split();
        u_core.xfer(mode_bank_reg, 8'h00, 1'b1, 8'h90, 1'b0);
        u_core.xfer(mode_bank_reg, 8'h01, 1'b1, 8'h25, 1'b0);
        u_core.xfer(mode_indirect, 8'h00, 1'b1, 8'h5a, 1'b0);
        u_core.xfer(mode_direct, 8'h90, 1'b1, 8'h77, 1'b0);
        u_core.xfer(mode_direct, 8'h25, 1'b1, 8'h3c, 1'b0);
        u_core.xfer(mode_bit, 8'h28, 1'b1, 8'h01, 1'b0);
        rd(mode_direct, 8'h90, 1'b0, 8'h00);
        rd(mode_indirect, 8'h00, 1'b0, 8'h5a);
        rd(mode_indirect, 8'h00, 1'b1, 8'h3d);
        accumulator = 8'h07;
        program_write_enable = 1;
        u_core.xfer(mode_direct, 8'hd0, 1'b1, 8'hfe, 1'b0);
        rd(mode_direct, 8'hd0, 1'b0, 8'hff);
        $display("split test done");
    endtask
    task automatic t_sfr();
        u_core.xfer(mode_direct, 8'h83, 1'b1, 8'ha5, 1'b0);
        chk("data_pointer_high_byte", 8'ha5, data_pointer_high_byte);
        rd(mode_direct, 8'h83, 1'b0, 8'ha5);
        u_core.xfer(mode_bit, 8'hd3, 1'b1, 8'h00, 1'b0);
        chk("active_bank", 8'h02, 8'(active_bank));
        chk("program_status_word", 8'hf7, program_status_word);
        rdb(8'hd0, 1'b1);
        rdb(8'h28, 1'b1);
        accumulator = 8'h03;
        u_core.xfer(mode_direct, 8'hd0, 1'b1, 8'h19, 1'b0);
        chk("program_status_word", 8'h18, program_status_word);
        chk("active_bank", 8'h03, 8'(active_bank));
        chk("movx_to_program", 8'h01, 8'(movx_to_program));
        program_write_enable = 0;
        #1 chk("movx_to_program", 8'h00, 8'(movx_to_program));
        $display("special function test done");
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clk) if (++cyc == 3000) begin
        num_errors++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge clk);
        #1 reset = 0;
        t_bank();
        t_split();
        t_sfr();
        test_done();
    end
endmodule

// ===== testbench/ram_chk_props.sv
/* Assertions on the data memory ports. Assumes the bind below onto the design. */
`timescale 1ns/1ns
module ram_chk
    import data_mem_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic rd_valid,
    input wire logic sfr_other,
    input wire logic movx_to_program,
    input wire logic program_write_enable,
    input wire access_mode_t mode,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] accumulator,
    input wire logic [7:0] program_status_word,
    input wire logic [7:0] data_pointer_high_byte,
    input wire logic [1:0] active_bank
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    property p_rv; rd_en |=> rd_valid; endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_bk; active_bank == program_status_word[4:3]; endproperty
    a_bk: assert property (p_bk) else $error("bank select mismatch");
    property p_par; program_status_word[0] == ^accumulator; endproperty
    a_par: assert property (p_par) else $error("parity mismatch");
    property p_pw; movx_to_program == program_write_enable; endproperty
    a_pw: assert property (p_pw) else $error("movx target mismatch");
    property p_sw; wr_en && mode == mode_direct && addr == 8'hd0
        |=> (program_status_word >> 1) == ($past(wr_data) >> 1); endproperty
    a_sw: assert property (p_sw) else $error("status write lost");
    property p_dp; wr_en && mode == mode_direct && addr == 8'h83
        |=> data_pointer_high_byte == $past(wr_data); endproperty
    a_dp: assert property (p_dp) else $error("pointer write lost");
    property p_sf; wr_en && mode == mode_direct && addr > 8'h7f
        && !(addr inside {8'h83, 8'hd0}) |-> sfr_other; endproperty
    a_sf: assert property (p_sf) else $error("direct high not special");
    property p_rm; mode == mode_indirect |-> !sfr_other; endproperty
    a_rm: assert property (p_rm) else $error("indirect left ram");
    c_rd: cover property (rd_en ##1 rd_valid);
    c_b3: cover property (active_bank == 2'h3);
    c_sf: cover property (sfr_other);
endmodule
bind internal_ram_bank_select ram_chk u_chk (
    .clk(clk),
    .reset(reset),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rd_valid(rd_valid),
    .sfr_other(sfr_other),
    .movx_to_program(movx_to_program),
    .program_write_enable(program_write_enable),
    .mode(mode),
    .addr(addr),
    .wr_data(wr_data),
    .accumulator(accumulator),
    .program_status_word(program_status_word),
    .data_pointer_high_byte(data_pointer_high_byte),
    .active_bank(active_bank)
);
